/* File: rtl/rcd_pkg.sv */
package rcd_pkg;
   // instruction and data widths
   localparam int INSN_W = 14;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   // program counter width: 13 bits covers the largest 8K space
   localparam int PC_W = 13;
   // variant program spaces in words
   localparam int SPACE_1K = 1024;
   localparam int SPACE_2K = 2048;
   localparam int SPACE_4K = 4096;
   localparam int SPACE_8K = 8192;
   // special register locations in the data map
   localparam logic [6:0] ADDR_INDIRECT = 7'h00;
   localparam logic [6:0] ADDR_PCL = 7'h02;
   localparam logic [6:0] ADDR_STATUS = 7'h03;
   localparam logic [6:0] ADDR_POINTER = 7'h04;
   localparam logic [6:0] ADDR_PCHIGH = 7'h0A;
   // status bit positions
   localparam int BIT_CARRY = 0;
   localparam int BIT_NIBBLE = 1;
   localparam int BIT_ZERO = 2;
   // reset values
   localparam logic [7:0] STATUS_RST = 8'h18;
   localparam logic [13:0] NOP_WORD = 14'h0000;
   localparam logic [12:0] PC_RST = 13'h0000;
   // quarter-rate phase count
   localparam int PHASES = 4;
   localparam logic [1:0] PHASE_LAST = 2'h3;
   localparam logic [1:0] PHASE_HALF = 2'h2;
   // instruction word fields: [13:12] group
   localparam logic [1:0] GRP_BYTE = 2'h0;
   localparam logic [1:0] GRP_BIT = 2'h1;
   localparam logic [1:0] GRP_JUMP = 2'h2;
   localparam logic [1:0] GRP_LIT = 2'h3;
   // byte-oriented operations, bits [11:8]
   localparam logic [3:0] OP_MOVWF = 4'h0;
   localparam logic [3:0] OP_CLR = 4'h1;
   localparam logic [3:0] OP_SUB = 4'h2;
   localparam logic [3:0] OP_DEC = 4'h3;
   localparam logic [3:0] OP_IOR = 4'h4;
   localparam logic [3:0] OP_AND = 4'h5;
   localparam logic [3:0] OP_XOR = 4'h6;
   localparam logic [3:0] OP_ADD = 4'h7;
   localparam logic [3:0] OP_MOV = 4'h8;
   localparam logic [3:0] OP_COM = 4'h9;
   localparam logic [3:0] OP_INC = 4'hA;
   localparam logic [3:0] OP_RRF = 4'hC;
   localparam logic [3:0] OP_RLF = 4'hD;
   localparam logic [3:0] OP_SWAP = 4'hE;
   // literal operations, bits [11:8]
   localparam logic [3:0] LOP_MOVLW = 4'h0;
   localparam logic [3:0] LOP_IORLW = 4'h8;
   localparam logic [3:0] LOP_ANDLW = 4'h9;
   localparam logic [3:0] LOP_XORLW = 4'hA;
   localparam logic [3:0] LOP_LITSUB = 4'hC;
   localparam logic [3:0] LOP_ADDLW = 4'hE;
   // alu result with its flags
   typedef struct packed {
      logic [7:0] value;
      logic carry;
      logic nibble;
      logic zero;
      logic upd_carry;
      logic upd_nz;
   } rcd_alu_t;
   // program fetch request
   typedef struct packed {
      logic [12:0] addr;
      logic strobe;
   } rcd_fetch_t;
endpackage

/* File: rtl/rcd_core.sv */
// Operation
// - instruction words are 14 bits, one each
// - one 14-bit word fetched per cycle
// - fetch overlaps execute, single-cycle non-branches
// - pc spans 1K/2K/4K/8K internal words
// - special registers, pc included, are data-mapped
// - any operation works on any register
// - 8-bit alu: add, subtract, shift, logic
// - two operands: accumulator plus file or literal
// - single operand: accumulator or one file
// - accumulator is unaddressed, implicit only
// - alu updates carry, nibble and zero flags
// - subtraction flags report borrow as inverted carry
// - quarter-rate clock out marks instruction cycles
// - master clear low holds the core reset
module rcd_core #(
   parameter int SPACE_WORDS = rcd_pkg::SPACE_8K
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_rc_mode,
   input wire logic [13:0] i_insn_word,
   input wire logic [7:0] i_file_rdata,
   output logic [12:0] o_fetch_addr,
   output logic o_fetch_strobe,
   output logic [6:0] o_file_addr,
   output logic [7:0] o_file_wdata,
   output logic o_file_we,
   output logic [7:0] o_accumulator,
   output logic [7:0] o_status,
   output logic o_clock_quarter_out
);
   ////////////////////////////////////////////////////////////////////////
   // declarations
   localparam logic [12:0] PC_MASK = 13'(SPACE_WORDS - 1); // variant span
   logic [1:0] phase_ff; // oscillator phase within one instruction cycle
   logic [12:0] pc_ff; // program counter
   logic [13:0] ir_ff; // instruction under execution
   logic flush_ff; // discard fetched word after a branch
   logic [7:0] acc_ff; // working accumulator, no data address
   logic [7:0] status_ff; // flags live here
   logic [7:0] pointer_ff; // indirect pointer
   logic [4:0] pchigh_ff; // upper pc latch
   // registered file ram port, one cycle behind the operand decode
   logic [6:0] faddr_ff; // operand address, indirect resolved
   logic [7:0] fwdata_ff; // write data
   logic fwe_ff; // write pulse
   logic clkq_ff; // quarter-rate clock out
   rcd_pkg::rcd_fetch_t fetch_ff; // fetch address and strobe travel together
   // combinational decode of the word under execution
   logic end_cycle; // last phase of an instruction cycle
   logic [1:0] grp; // instruction group
   logic [3:0] op; // operation within the group
   logic dest_file; // result goes to the file, not the accumulator
   logic [6:0] eff_addr; // operand address after indirection
   logic [7:0] file_val; // operand as read
   logic [7:0] lit; // immediate byte
   // alu result and the flags it may touch
   rcd_pkg::rcd_alu_t res;
   // control-flow decision for the current word
   logic branch; // discard the fetched word
   logic [12:0] branch_target; // where fetch resumes
   logic skip; // taken bit-test skip

   ////////////////////////////////////////////////////////////////////////
   // helpers
   // add with carry in; reused by add and subtract, file and literal forms
   function automatic rcd_pkg::rcd_alu_t add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
      rcd_pkg::rcd_alu_t r;
      logic [4:0] lo;
      logic [8:0] full;
      r = '0;
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      r.value = full[7:0];
      r.carry = full[8];
      r.nibble = lo[4];
      r.zero = (full[7:0] == 8'h00);
      return r;
   endfunction

   // logic result, only zero affected
   function automatic rcd_pkg::rcd_alu_t logic8(input logic [7:0] v);
      rcd_pkg::rcd_alu_t r;
      r = '0;
      r.value = v;
      r.zero = (v == 8'h00);
      r.upd_nz = 1'b1;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // decode
   assign end_cycle = (phase_ff == rcd_pkg::PHASE_LAST);
   assign grp = ir_ff[13:12];
   assign op = ir_ff[11:8];
   assign dest_file = ir_ff[7];
   assign lit = ir_ff[7:0];
   // indirect slot redirects through the pointer register
   assign eff_addr = (ir_ff[6:0] == rcd_pkg::ADDR_INDIRECT) ? pointer_ff[6:0] : ir_ff[6:0];

   // read mux: special registers come from the core, rest from file ram
   // pc low byte reads back as the address of the next word
   always_comb begin
      unique case (eff_addr)
         rcd_pkg::ADDR_PCL: file_val = pc_ff[7:0];
         rcd_pkg::ADDR_STATUS: file_val = status_ff;
         rcd_pkg::ADDR_POINTER: file_val = pointer_ff;
         rcd_pkg::ADDR_PCHIGH: file_val = {3'h0, pchigh_ff};
         default: file_val = i_file_rdata;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // alu
   // unused codes fall back to moves, so no word is illegal
   always_comb begin
      res = '0;
      skip = 1'b0;
      if (grp == rcd_pkg::GRP_BYTE) begin
         unique case (op)
            rcd_pkg::OP_MOVWF: res = '{value: acc_ff, default: 1'b0};
            rcd_pkg::OP_CLR: res = logic8(8'h00);
            rcd_pkg::OP_SUB: begin
               // file plus inverted accumulator plus one: carry set means no borrow
               res = add8(file_val, ~acc_ff, 1'b1);
               res.upd_carry = 1'b1;
               res.upd_nz = 1'b1;
            end
            rcd_pkg::OP_DEC: res = logic8(file_val - 8'h01);
            rcd_pkg::OP_IOR: res = logic8(acc_ff | file_val);
            rcd_pkg::OP_AND: res = logic8(acc_ff & file_val);
            rcd_pkg::OP_XOR: res = logic8(acc_ff ^ file_val);
            rcd_pkg::OP_ADD: begin
               res = add8(acc_ff, file_val, 1'b0);
               res.upd_carry = 1'b1;
               res.upd_nz = 1'b1;
            end
            rcd_pkg::OP_MOV: res = logic8(file_val);
            rcd_pkg::OP_COM: res = logic8(~file_val);
            rcd_pkg::OP_INC: res = logic8(file_val + 8'h01);
            rcd_pkg::OP_RRF: begin
               // shifts pass through carry, zero untouched
               res = '{value: {status_ff[rcd_pkg::BIT_CARRY], file_val[7:1]}, carry: file_val[0],
                       upd_carry: 1'b1, default: 1'b0};
            end
            rcd_pkg::OP_RLF: begin
               res = '{value: {file_val[6:0], status_ff[rcd_pkg::BIT_CARRY]}, carry: file_val[7],
                       upd_carry: 1'b1, default: 1'b0};
            end
            rcd_pkg::OP_SWAP: res = '{value: {file_val[3:0], file_val[7:4]}, default: 1'b0};
            default: res = '{value: file_val, default: 1'b0}; // unused codes move only
         endcase
         // inc/dec, clear, complement, move and logic ops only drive the zero flag; keep nibble untouched
         if (op == rcd_pkg::OP_INC || op == rcd_pkg::OP_DEC || op == rcd_pkg::OP_IOR || op == rcd_pkg::OP_AND
             || op == rcd_pkg::OP_XOR || op == rcd_pkg::OP_MOV || op == rcd_pkg::OP_COM || op == rcd_pkg::OP_CLR) begin
            res.nibble = status_ff[rcd_pkg::BIT_NIBBLE];
            res.upd_nz = 1'b1;
         end
      end else if (grp == rcd_pkg::GRP_BIT) begin
         // bit ops: [11:10] kind, [9:7] bit index; test kinds skip
         res = '{value: file_val, default: 1'b0};
         unique case (ir_ff[11:10])
            2'h0: res.value[ir_ff[9:7]] = 1'b0;
            2'h1: res.value[ir_ff[9:7]] = 1'b1;
            2'h2: skip = ~file_val[ir_ff[9:7]];
            2'h3: skip = file_val[ir_ff[9:7]];
         endcase
      end else if (grp == rcd_pkg::GRP_LIT) begin
         unique case (op)
            rcd_pkg::LOP_LITSUB: begin
               res = add8(lit, ~acc_ff, 1'b1);
               res.upd_carry = 1'b1;
               res.upd_nz = 1'b1;
            end
            rcd_pkg::LOP_ADDLW: begin
               res = add8(acc_ff, lit, 1'b0);
               res.upd_carry = 1'b1;
               res.upd_nz = 1'b1;
            end
            rcd_pkg::LOP_IORLW: res = logic8(acc_ff | lit);
            rcd_pkg::LOP_ANDLW: res = logic8(acc_ff & lit);
            rcd_pkg::LOP_XORLW: res = logic8(acc_ff ^ lit);
            default: res = '{value: lit, default: 1'b0}; // literal load
         endcase
         if (op != rcd_pkg::LOP_LITSUB && op != rcd_pkg::LOP_ADDLW) begin
            res.nibble = status_ff[rcd_pkg::BIT_NIBBLE];
            res.carry = status_ff[rcd_pkg::BIT_CARRY];
         end
      end
   end

   // branch: jump group, or a write to the low pc byte, or a taken skip
   assign branch = ~flush_ff & ((grp == rcd_pkg::GRP_JUMP) | skip
                   | (grp == rcd_pkg::GRP_BYTE & dest_file & eff_addr == rcd_pkg::ADDR_PCL)
                   | (grp == rcd_pkg::GRP_BIT & ~ir_ff[11] & eff_addr == rcd_pkg::ADDR_PCL));
   assign branch_target = (grp == rcd_pkg::GRP_JUMP) ? ({pchigh_ff[4:3], ir_ff[10:0]} & PC_MASK)
                        : skip ? ((pc_ff + 13'h0001) & PC_MASK) // skipped word is already fetched, go past it
                        : ({pchigh_ff, res.value} & PC_MASK);

   ////////////////////////////////////////////////////////////////////////
   // phase counter and quarter clock out
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         phase_ff <= 2'h0;
         clkq_ff <= 1'b0;
      end else begin
         // free-running, wraps once every instruction cycle
         phase_ff <= phase_ff + 2'h1;
         // high for the second half of every instruction cycle, low outside rc mode
         clkq_ff <= i_rc_mode & ((phase_ff + 2'h1) >= rcd_pkg::PHASE_HALF);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fetch stage: pc and instruction register
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pc_ff <= rcd_pkg::PC_RST;
         ir_ff <= rcd_pkg::NOP_WORD;
         flush_ff <= 1'b1;
         fetch_ff <= '{addr: rcd_pkg::PC_RST, strobe: 1'b0};
      end else begin
         fetch_ff.strobe <= (phase_ff == rcd_pkg::PHASE_HALF);
         if (end_cycle) begin
            // next word latched while current executes
            ir_ff <= i_insn_word;
            if (branch) begin
               pc_ff <= branch_target;
               flush_ff <= 1'b1; // two-cycle branch
            end else begin
               pc_ff <= (pc_ff + 13'h0001) & PC_MASK;
               flush_ff <= 1'b0;
            end
         end
         // pc sampled mid-cycle so the word is settled at the phase 3 edge
         if (phase_ff == rcd_pkg::PHASE_HALF) begin
            fetch_ff.addr <= pc_ff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // execute: accumulator, status and special registers
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         acc_ff <= 8'h00;
         status_ff <= rcd_pkg::STATUS_RST;
         pointer_ff <= 8'h00;
         pchigh_ff <= 5'h00;
      end else if (end_cycle && !flush_ff) begin
         // accumulator is only ever an implicit destination
         if (grp == rcd_pkg::GRP_LIT || (grp == rcd_pkg::GRP_BYTE && !dest_file && op != rcd_pkg::OP_MOVWF)) begin
            acc_ff <= res.value;
         end
         // special registers first, so that alu flag updates win over the write
         if ((grp == rcd_pkg::GRP_BYTE && dest_file) || grp == rcd_pkg::GRP_BIT) begin
            unique case (eff_addr)
               rcd_pkg::ADDR_STATUS: status_ff <= res.value;
               rcd_pkg::ADDR_POINTER: pointer_ff <= res.value;
               rcd_pkg::ADDR_PCHIGH: pchigh_ff <= res.value[4:0];
               default: ;
            endcase
         end
         if (res.upd_carry) begin
            status_ff[rcd_pkg::BIT_CARRY] <= res.carry;
         end
         if (res.upd_nz) begin
            status_ff[rcd_pkg::BIT_ZERO] <= res.zero;
         end
         if (res.upd_nz && res.upd_carry) begin
            status_ff[rcd_pkg::BIT_NIBBLE] <= res.nibble;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // file ram port, registered
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         faddr_ff <= 7'h00;
         fwdata_ff <= 8'h00;
         fwe_ff <= 1'b0;
      end else begin
         faddr_ff <= eff_addr;
         fwdata_ff <= res.value;
         // write pulse follows the commit edge by one cycle
         fwe_ff <= end_cycle & ~flush_ff & (((grp == rcd_pkg::GRP_BYTE) & dest_file) | (grp == rcd_pkg::GRP_BIT));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, each straight from a flip-flop
   assign o_fetch_addr = fetch_ff.addr;
   assign o_fetch_strobe = fetch_ff.strobe;
   assign o_file_addr = faddr_ff;
   assign o_file_wdata = fwdata_ff;
   assign o_file_we = fwe_ff;
   assign o_accumulator = acc_ff;
   assign o_status = status_ff;
   assign o_clock_quarter_out = clkq_ff;
endmodule

/* File: verif/rcd_core_sva.sv */
module rcd_core_sva #(
   parameter int SPACE_WORDS = rcd_pkg::SPACE_8K
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_rc_mode,
   input wire logic [13:0] i_insn_word,
   input wire logic [7:0] i_file_rdata,
   input wire logic [12:0] o_fetch_addr,
   input wire logic o_fetch_strobe,
   input wire logic [6:0] o_file_addr,
   input wire logic [7:0] o_file_wdata,
   input wire logic o_file_we,
   input wire logic [7:0] o_accumulator,
   input wire logic [7:0] o_status,
   input wire logic o_clock_quarter_out
);
   // one clock domain, master clear disables all but the reset check
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (!i_reset_n);
   // three quiet cycles, then the next fetch
   sequence s_gap;
      !o_fetch_strobe[*3] ##1 o_fetch_strobe;
   endsequence
   // two high, two low, high again
   sequence s_quarter;
      o_clock_quarter_out[*2] ##1 !o_clock_quarter_out[*2] ##1 o_clock_quarter_out;
   endsequence
   property p_fetch_rate;
      o_fetch_strobe |=> s_gap;
   endproperty
   a_fetch_rate: assert property (p_fetch_rate) else $error("fetch strobe spacing wrong");
   // only holds without jumps or pc writes; a taken skip, as in the bench's t_skip, still steps fetch by one
   property p_fetch_inc;
      o_fetch_strobe ##4 o_fetch_strobe |-> o_fetch_addr == $past(o_fetch_addr, 4) + 13'h1;
   endproperty
   a_fetch_inc: assert property (p_fetch_inc) else $error("fetch address did not step by one");
   property p_file_we;
      o_file_we |-> $past(o_fetch_strobe) ##1 !o_file_we[*3];
   endproperty
   a_file_we: assert property (p_file_we) else $error("file write pulse misplaced");
   property p_commit;
      (!$stable(o_accumulator) || !$stable(o_status)) |-> $past(o_fetch_strobe);
   endproperty
   a_commit: assert property (p_commit) else $error("result changed off the commit edge");
   property p_quarter_off;
      !i_rc_mode && !$past(i_rc_mode) |-> !o_clock_quarter_out;
   endproperty
   a_quarter_off: assert property (p_quarter_off) else $error("quarter clock runs outside rc mode");
   property p_quarter_rate;
      $rose(o_clock_quarter_out) && i_rc_mode |-> s_quarter;
   endproperty
   a_quarter_rate: assert property (p_quarter_rate) else $error("quarter clock shape wrong");
   // async clear must show while held low, so no disable here
   property p_reset_state;
      disable iff (1'b0) !i_reset_n |-> o_status == rcd_pkg::STATUS_RST && o_accumulator == 8'h00 && !o_file_we;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("outputs not cleared in reset");
   property p_pc_range;
      int'(o_fetch_addr) < SPACE_WORDS;
   endproperty
   a_pc_range: assert property (p_pc_range) else $error("fetch address beyond program space");
endmodule

/* File: verif/rcd_mem_model.sv */
module rcd_mem_model (
   input wire logic i_clock,
   input wire logic [12:0] i_fetch_addr,
   input wire logic [6:0] i_file_addr,
   input wire logic [7:0] i_file_wdata,
   input wire logic i_file_we,
   output logic [13:0] o_insn_word,
   output logic [7:0] o_file_rdata
);
   logic [13:0] prog_mem [0:8191]; // whole 8k space, first 64 words loaded by the bench
   logic [7:0] file_mem [0:127]; // file ram, combinational read
   initial begin
      for (int i = 0; i < 128; i++) begin
         file_mem[i] = 8'h00;
      end
   end
   // one whole word per address, no external program store
   assign o_insn_word = prog_mem[i_fetch_addr];
   assign o_file_rdata = file_mem[i_file_addr];
   // write on the strobe edge only
   always @(posedge i_clock) begin
      if (i_file_we) begin
         file_mem[i_file_addr] <= i_file_wdata;
      end
   end
endmodule

/* File: verif/rcd_core_bench.sv */
module rcd_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef logic [13:0] rcd_prog_t [$];
   logic i_clock = 1'b1; // first edge falls, so reset lands before any sample
   logic i_reset_n = 1'b1; // pulled low at the first falling edge
   logic i_rc_mode = 1'b0;
   logic [13:0] i_insn_word;
   logic [7:0] i_file_rdata, o_file_wdata, o_accumulator, o_status;
   logic [12:0] o_fetch_addr;
   logic [6:0] o_file_addr;
   logic o_fetch_strobe, o_file_we, o_clock_quarter_out;
   int bad_count = 0;
   int comparisons = 0;
   int cycle_count = 0;
   int n;
   always #20 i_clock = ~i_clock;
   rcd_core #(.SPACE_WORDS(rcd_pkg::SPACE_8K)) rcd_core_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
      .i_rc_mode(i_rc_mode), .i_insn_word(i_insn_word), .i_file_rdata(i_file_rdata),
      .o_fetch_addr(o_fetch_addr), .o_fetch_strobe(o_fetch_strobe), .o_file_addr(o_file_addr),
      .o_file_wdata(o_file_wdata), .o_file_we(o_file_we), .o_accumulator(o_accumulator),
      .o_status(o_status), .o_clock_quarter_out(o_clock_quarter_out));
   rcd_mem_model rcd_mem_model_i (.i_clock(i_clock), .i_fetch_addr(o_fetch_addr), .i_file_addr(o_file_addr),
      .i_file_wdata(o_file_wdata), .i_file_we(o_file_we), .o_insn_word(i_insn_word),
      .o_file_rdata(i_file_rdata));
   task automatic stop_test();
      if (bad_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // hang guard: whole run needs well under a thousand cycles
   always @(posedge i_clock) begin
      cycle_count++;
      if (cycle_count == 5000) begin
         bad_count++;
         stop_test();
      end
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   function automatic logic [13:0] lit(input logic [3:0] op, input logic [7:0] k);
      return {rcd_pkg::GRP_LIT, op, k};
   endfunction
   function automatic logic [13:0] byt(input logic [3:0] op, input logic d, input logic [6:0] f);
      return {rcd_pkg::GRP_BYTE, op, d, f};
   endfunction
   // word 0 runs as a no-op after reset, so code starts at word 1
   task automatic run_prog(input rcd_prog_t prog, input logic rc);
      @(negedge i_clock);
      i_reset_n = 1'b0;
      i_rc_mode = rc;
      for (int i = 0; i < 64; i++) begin
         rcd_mem_model_i.prog_mem[i] = (i > 0 && i <= prog.size()) ? prog[i - 1] : rcd_pkg::NOP_WORD;
      end
      repeat (5) @(negedge i_clock);
      i_reset_n = 1'b1;
      repeat (4 * (prog.size() + 3)) @(negedge i_clock);
   endtask
   // load a literal into the accumulator, then one literal operation
   task automatic lit_pair(input logic [3:0] op, input logic [7:0] a, input logic [7:0] k,
         input logic [7:0] w, input logic [2:0] fl);
      run_prog('{lit(rcd_pkg::LOP_MOVLW, a), lit(op, k)}, 1'b0);
      check("accumulator", o_accumulator, w);
      check("flags", {5'h00, o_status[2:0]}, {5'h00, fl});
   endtask
   task automatic t_add();
      lit_pair(rcd_pkg::LOP_ADDLW, 8'h0F, 8'h01, 8'h10, 3'h2);
      lit_pair(rcd_pkg::LOP_ADDLW, 8'hFF, 8'h01, 8'h00, 3'h7);
   endtask
   // flags read as inverted borrow
   task automatic t_sub();
      lit_pair(rcd_pkg::LOP_LITSUB, 8'h01, 8'h00, 8'hFF, 3'h0);
      lit_pair(rcd_pkg::LOP_LITSUB, 8'h01, 8'h05, 8'h04, 3'h3);
      lit_pair(rcd_pkg::LOP_LITSUB, 8'h05, 8'h05, 8'h00, 3'h7);
   endtask
   // logic ops touch zero only; a plain load touches nothing
   task automatic t_logic();
      lit_pair(rcd_pkg::LOP_ANDLW, 8'hF0, 8'h0F, 8'h00, 3'h4);
      lit_pair(rcd_pkg::LOP_IORLW, 8'hF0, 8'h0F, 8'hFF, 3'h0);
      lit_pair(rcd_pkg::LOP_XORLW, 8'hFF, 8'hFF, 8'h00, 3'h4);
      lit_pair(rcd_pkg::LOP_MOVLW, 8'h11, 8'h00, 8'h00, 3'h0);
   endtask
   // store, add into file, subtract into accumulator, store high
   task automatic t_file();
      run_prog('{lit(rcd_pkg::LOP_MOVLW, 8'h5A), byt(rcd_pkg::OP_MOVWF, 1'b1, 7'h20),
         lit(rcd_pkg::LOP_MOVLW, 8'h03), byt(rcd_pkg::OP_ADD, 1'b1, 7'h20),
         byt(rcd_pkg::OP_SUB, 1'b0, 7'h20), byt(rcd_pkg::OP_MOVWF, 1'b1, 7'h7F)}, 1'b0);
      check("file 20", rcd_mem_model_i.file_mem[32], 8'h5D);
      check("accumulator", o_accumulator, 8'h5A);
      check("flags", {5'h00, o_status[2:0]}, 8'h03);
      check("file 7F", rcd_mem_model_i.file_mem[127], 8'h5A);
   endtask
   // a taken bit-test skip drops exactly the next word
   task automatic t_skip();
      run_prog('{lit(rcd_pkg::LOP_MOVLW, 8'h01), {rcd_pkg::GRP_BIT, 2'h2, 3'h0, 7'h21},
         lit(rcd_pkg::LOP_MOVLW, 8'h55), lit(rcd_pkg::LOP_ADDLW, 8'h02)}, 1'b0);
      check("accumulator", o_accumulator, 8'h03);
      check("flags", {5'h00, o_status[2:0]}, 8'h00);
   endtask
   // count rising edges of the quarter clock over 16 cycles
   task automatic t_quarter();
      logic prev;
      for (int m = 1; m >= 0; m--) begin
         run_prog('{lit(rcd_pkg::LOP_MOVLW, 8'h01)}, m[0]);
         n = 0;
         prev = o_clock_quarter_out;
         repeat (16) begin
            @(negedge i_clock);
            n += (o_clock_quarter_out === 1'b1 && prev === 1'b0) ? 1 : 0;
            prev = o_clock_quarter_out;
         end
         check("quarter rises", 8'(n), m ? 8'h04 : 8'h00);
      end
   endtask
   // master clear in mid-run wipes the result at once
   task automatic t_reset();
      run_prog('{lit(rcd_pkg::LOP_MOVLW, 8'h33)}, 1'b0);
      check("accumulator", o_accumulator, 8'h33);
      i_reset_n = 1'b0;
      @(negedge i_clock);
      check("accumulator", o_accumulator, 8'h00);
      check("status", o_status, rcd_pkg::STATUS_RST);
   endtask
   initial begin
      t_add();
      t_sub();
      t_logic();
      t_file();
      t_skip();
      t_quarter();
      t_reset();
      stop_test();
   end
endmodule
bind rcd_core rcd_core_sva #(.SPACE_WORDS(SPACE_WORDS)) rcd_core_sva_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
   .i_rc_mode(i_rc_mode), .i_insn_word(i_insn_word), .i_file_rdata(i_file_rdata),
   .o_fetch_addr(o_fetch_addr), .o_fetch_strobe(o_fetch_strobe), .o_file_addr(o_file_addr),
   .o_file_wdata(o_file_wdata), .o_file_we(o_file_we), .o_accumulator(o_accumulator),
   .o_status(o_status), .o_clock_quarter_out(o_clock_quarter_out));
